// ===== logic/pxbs_pkg.sv
package pxbs_pkg;
   // register byte offsets
   localparam logic [7:0] PXBS_OFF_STATUS = 8'h84;
   localparam logic [7:0] PXBS_OFF_SPLIT = 8'h88;
   localparam logic [7:0] PXBS_OFF_IRQ_STAT = 8'hC0;
   localparam logic [7:0] PXBS_OFF_IRQ_MASK = 8'hC4;
   localparam logic [7:0] PXBS_OFF_BUSNUM = 8'hC8;
   // status field positions
   localparam int PXBS_FN_LSB = 0;
   localparam int PXBS_DEV_LSB = 3;
   localparam int PXBS_BUS_LSB = 8;
   localparam int PXBS_CAP64_BIT = 16;
   localparam int PXBS_CAP133_BIT = 17;
   localparam int PXBS_DISC_BIT = 18;
   localparam int PXBS_UNEXP_BIT = 19;
   localparam int PXBS_OVR_BIT = 20;
   localparam int PXBS_DLY_BIT = 21;
   // event indices inside the 4-bit flag vectors
   localparam int PXBS_EV_DISC = 0;
   localparam int PXBS_EV_UNEXP = 1;
   localparam int PXBS_EV_OVR = 2;
   localparam int PXBS_EV_DLY = 3;
   localparam int PXBS_NEV = 4;
   // reset values, split capability, no-check limit and config write command
   localparam logic [2:0] PXBS_FN_RST = 3'h0;
   localparam logic [4:0] PXBS_DEV_RST = 5'h1F;
   localparam logic [7:0] PXBS_BUS_RST = 8'hFF;
   localparam logic [15:0] PXBS_SPLIT_CAP = 16'h0010;
   localparam logic [15:0] PXBS_LIMIT_RST = 16'h0010;
   localparam logic [15:0] PXBS_LIMIT_NOCHK = 16'hFFFF;
   localparam logic [3:0] PXBS_CFG_WRITE = 4'hB;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pxbs_bus_req_t;

   typedef struct packed {
      logic valid;
      logic [3:0] cmd;
      logic idsel;
      logic [15:0] ad;
   } pxbs_cfg_t;

   typedef struct packed {
      logic [2:0] fn;
      logic [4:0] dev;
      logic [7:0] bus;
      logic [3:0] flags;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [15:0] limit;
      logic [31:0] rdata;
      logic rst_d;
      logic cap64;
      logic [2:0] req64_sync;
   } pxbs_state_t;
endpackage

// ===== logic/pxbs_regs.sv
module pxbs_regs
   import pxbs_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // primary bus configuration address phase
   input wire logic cfg_valid_i,
   input wire logic [3:0] cfg_cmd_i,
   input wire logic cfg_idsel_i,
   input wire logic [15:0] cfg_ad_i,
   // mode and bus reset straps
   input wire logic reverse_i,
   input wire logic pci_rstn_i,
   input wire logic req64_n_i,
   // split transaction events
   input wire logic ev_discard_i,
   input wire logic ev_unexp_i,
   input wire logic [15:0] unexp_reqid_i,
   input wire logic ev_overrun_i,
   input wire logic [15:0] req_size_i,
   input wire logic [15:0] outstanding_i,
   input wire logic split_req_i,
   // split forwarding and identity
   output logic split_fwd_ok_o,
   output logic [15:0] completer_id_o,
   // interrupt
   output logic irq_o
);
   pxbs_state_t s_r, s_nxt;
   logic [3:0] ev;
   logic room_ok;
   logic [16:0] need;
   logic [31:0] status_word;
   logic tgt;

   function automatic logic [3:0] w1c_mask(input logic [31:0] w);
      return {w[PXBS_DLY_BIT], w[PXBS_OVR_BIT], w[PXBS_UNEXP_BIT], w[PXBS_DISC_BIT]};
   endfunction

   always_comb begin
      need = {1'b0, outstanding_i} + {1'b0, req_size_i};
      // limit check, bypassed at FFFFh
      // unchecked forwarding
      room_ok = (s_r.limit == PXBS_LIMIT_NOCHK) || (need <= {1'b0, s_r.limit});
      tgt = cfg_valid_i && cfg_cmd_i == PXBS_CFG_WRITE && cfg_idsel_i && cfg_ad_i[10:8] == s_r.fn;
      ev[PXBS_EV_DISC] = ev_discard_i && !reverse_i;
      ev[PXBS_EV_UNEXP] = ev_unexp_i && reverse_i && unexp_reqid_i == {s_r.bus, s_r.dev, s_r.fn};
      ev[PXBS_EV_OVR] = ev_overrun_i;
      ev[PXBS_EV_DLY] = split_req_i && !room_ok;
      status_word = 32'h0;
      status_word[PXBS_FN_LSB +: 3] = s_r.fn;
      status_word[PXBS_DEV_LSB +: 5] = s_r.dev;
      status_word[PXBS_BUS_LSB +: 8] = s_r.bus;
      status_word[PXBS_CAP64_BIT] = reverse_i && s_r.cap64;
      status_word[PXBS_CAP133_BIT] = reverse_i;
      status_word[PXBS_DISC_BIT] = s_r.flags[PXBS_EV_DISC] && !reverse_i;
      status_word[PXBS_UNEXP_BIT] = s_r.flags[PXBS_EV_UNEXP] && reverse_i;
      status_word[PXBS_OVR_BIT] = s_r.flags[PXBS_EV_OVR];
      status_word[PXBS_DLY_BIT] = s_r.flags[PXBS_EV_DLY];

      s_nxt = s_r;
      s_nxt.req64_sync = {s_r.req64_sync[1:0], ~req64_n_i};
      s_nxt.rst_d = pci_rstn_i;
      // sample REQ64 at bus reset release
      if (pci_rstn_i && !s_r.rst_d) begin
         s_nxt.cap64 = s_r.req64_sync[2] & s_r.req64_sync[1];
      end
      // function number capture on any config write with idsel; device number only when the function matches
      if (cfg_valid_i && cfg_cmd_i == PXBS_CFG_WRITE && cfg_idsel_i) begin
         s_nxt.fn = cfg_ad_i[10:8];
      end
      if (tgt) begin
         s_nxt.dev = cfg_ad_i[15:11];
      end
      // write one to clear, set wins
      if (wr_i && addr_i == PXBS_OFF_STATUS) begin
         s_nxt.flags = s_r.flags & ~w1c_mask(wdata_i);
      end
      s_nxt.flags = s_nxt.flags | ev;
      if (wr_i && addr_i == PXBS_OFF_SPLIT) begin
         s_nxt.limit = wdata_i[31:16];
      end
      if (wr_i && addr_i == PXBS_OFF_IRQ_MASK) begin
         s_nxt.irq_mask = wdata_i[3:0];
      end
      if (wr_i && addr_i == PXBS_OFF_BUSNUM) begin
         s_nxt.bus = wdata_i[7:0];
      end
      if (rd_i && addr_i == PXBS_OFF_IRQ_STAT) begin
         s_nxt.irq_stat = 4'h0;
      end
      s_nxt.irq_stat = s_nxt.irq_stat | ev;
      s_nxt.rdata = 32'h0;
      if (rd_i) begin
         case (addr_i)
            PXBS_OFF_STATUS: s_nxt.rdata = status_word;
            PXBS_OFF_SPLIT: s_nxt.rdata = {s_r.limit, PXBS_SPLIT_CAP};
            PXBS_OFF_IRQ_STAT: s_nxt.rdata = {28'h0000000, s_r.irq_stat};
            PXBS_OFF_IRQ_MASK: s_nxt.rdata = {28'h0000000, s_r.irq_mask};
            PXBS_OFF_BUSNUM: s_nxt.rdata = {24'h000000, s_r.bus};
            default: s_nxt.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r.fn <= PXBS_FN_RST;
         s_r.dev <= PXBS_DEV_RST;
         s_r.bus <= PXBS_BUS_RST;
         s_r.flags <= 4'h0;
         s_r.irq_stat <= 4'h0;
         s_r.irq_mask <= 4'h0;
         s_r.limit <= PXBS_LIMIT_RST;
         s_r.rdata <= 32'h0;
         s_r.rst_d <= 1'b0;
         s_r.cap64 <= 1'b0;
         s_r.req64_sync <= 3'h0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o = s_r.rdata;
   assign split_fwd_ok_o = room_ok;
   assign completer_id_o = {s_r.bus, s_r.dev, s_r.fn};
   assign irq_o = |(s_r.irq_stat & s_r.irq_mask);

   dev_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i) tgt |=> s_r.dev == $past(cfg_ad_i[15:11]))
      else $error("device field not loaded");
   dev_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (cfg_valid_i && !cfg_idsel_i) |=> $stable(s_r.dev)) else $error("device changed without idsel");
   cap133_mode_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_STATUS |=> rdata_o[PXBS_CAP133_BIT] == $past(reverse_i))
      else $error("133 capability wrong");
   resv_zero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_STATUS |=> rdata_o[31:22] == 10'h000) else $error("reserved bits set");
   ovr_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ev_overrun_i |=> s_r.flags[PXBS_EV_OVR]) else $error("overrun flag not set");
   w1c_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == PXBS_OFF_STATUS && wdata_i[PXBS_DLY_BIT] && !ev[PXBS_EV_DLY] |=> !s_r.flags[PXBS_EV_DLY])
      else $error("delay flag not cleared");
   nochk_fwd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_r.limit == PXBS_LIMIT_NOCHK |-> split_fwd_ok_o) else $error("bypass limit blocked");
   dly_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      split_req_i && !split_fwd_ok_o |=> s_r.flags[PXBS_EV_DLY]) else $error("delay flag missing");
   cap_const_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_SPLIT |=> rdata_o[15:0] == PXBS_SPLIT_CAP) else $error("capability wrong");

   // bus access steps
   sequence rd_status_s;
      rd_i && addr_i == PXBS_OFF_STATUS;
   endsequence
   sequence rd_split_s;
      rd_i && addr_i == PXBS_OFF_SPLIT;
   endsequence
   sequence wr_split_s;
      wr_i && addr_i == PXBS_OFF_SPLIT;
   endsequence
   sequence cfg_tgt_s;
      cfg_valid_i && cfg_cmd_i == PXBS_CFG_WRITE && cfg_idsel_i && cfg_ad_i[10:8] == s_r.fn;
   endsequence
   sequence wr_ovr_clr_s;
      wr_i && addr_i == PXBS_OFF_STATUS && wdata_i[PXBS_OVR_BIT] && !ev_overrun_i;
   endsequence

   fn_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_valid_i && cfg_cmd_i == PXBS_CFG_WRITE && cfg_idsel_i |=> s_r.fn == $past(cfg_ad_i[10:8]))
      else $error("function field not loaded");
   fn_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !(cfg_valid_i && cfg_idsel_i) |=> $stable(s_r.fn))
      else $error("function field changed");
   fn_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_status_s |=> rdata_o[2:0] == $past(s_r.fn))
      else $error("function field read wrong");
   dev_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_status_s |=> rdata_o[7:3] == $past(s_r.dev))
      else $error("device field read wrong");
   dev_cmd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_valid_i && cfg_cmd_i != PXBS_CFG_WRITE |=> $stable(s_r.dev))
      else $error("device changed on other command");
   dev_fnmiss_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_valid_i && cfg_ad_i[10:8] != s_r.fn |=> $stable(s_r.dev))
      else $error("device changed on other function");
   dev_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !cfg_valid_i |=> $stable(s_r.dev))
      else $error("device changed without address phase");
   dev_seq_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cfg_tgt_s ##1 rd_status_s |=> rdata_o[7:3] == $past(cfg_ad_i[15:11], 2))
      else $error("loaded device not read back");

   bus_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_status_s |=> rdata_o[15:8] == $past(s_r.bus))
      else $error("bus field read wrong");
   bus_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == PXBS_OFF_BUSNUM |=> s_r.bus == $past(wdata_i[7:0]))
      else $error("bus number not written");
   cid_status_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_status_s |=> rdata_o[15:0] == $past(completer_id_o))
      else $error("completer id differs from status");

   cap64_fwd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_STATUS && !reverse_i |=> !rdata_o[PXBS_CAP64_BIT])
      else $error("64-bit capability set in forward mode");
   cap64_rev_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_STATUS && reverse_i |=> rdata_o[PXBS_CAP64_BIT] == $past(s_r.cap64))
      else $error("64-bit capability read wrong");
   cap64_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !(pci_rstn_i && !s_r.rst_d) |=> $stable(s_r.cap64))
      else $error("64-bit strap changed");

   disc_rev_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_STATUS && reverse_i |=> !rdata_o[PXBS_DISC_BIT])
      else $error("discard bit set in reverse mode");
   disc_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ev_discard_i && !reverse_i |=> s_r.flags[PXBS_EV_DISC])
      else $error("discard flag not set");
   disc_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !s_r.flags[PXBS_EV_DISC] && !ev_discard_i |=> !s_r.flags[PXBS_EV_DISC])
      else $error("discard flag set without event");
   unexp_fwd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_STATUS && !reverse_i |=> !rdata_o[PXBS_UNEXP_BIT])
      else $error("unexpected bit set in forward mode");
   unexp_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ev_unexp_i && reverse_i && unexp_reqid_i == completer_id_o |=> s_r.flags[PXBS_EV_UNEXP])
      else $error("unexpected flag not set");
   unexp_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_STATUS && reverse_i |=> rdata_o[PXBS_UNEXP_BIT] == $past(s_r.flags[PXBS_EV_UNEXP]))
      else $error("unexpected bit read wrong");
   unexp_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !s_r.flags[PXBS_EV_UNEXP] && !ev_unexp_i |=> !s_r.flags[PXBS_EV_UNEXP])
      else $error("unexpected flag set without event");

   ovr_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_status_s |=> rdata_o[PXBS_OVR_BIT] == $past(s_r.flags[PXBS_EV_OVR]))
      else $error("overrun bit read wrong");
   ovr_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !s_r.flags[PXBS_EV_OVR] && !ev_overrun_i |=> !s_r.flags[PXBS_EV_OVR])
      else $error("overrun flag set without event");
   dly_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_status_s |=> rdata_o[PXBS_DLY_BIT] == $past(s_r.flags[PXBS_EV_DLY]))
      else $error("delayed bit read wrong");
   dly_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !s_r.flags[PXBS_EV_DLY] && !(split_req_i && !split_fwd_ok_o) |=> !s_r.flags[PXBS_EV_DLY])
      else $error("delayed flag set without cause");
   room_short_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_r.limit != PXBS_LIMIT_NOCHK && {1'b0, outstanding_i} + {1'b0, req_size_i} > {1'b0, s_r.limit}
      |-> !split_fwd_ok_o)
      else $error("request forwarded beyond limit");
   room_ok_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      {1'b0, outstanding_i} + {1'b0, req_size_i} <= {1'b0, s_r.limit} |-> split_fwd_ok_o)
      else $error("request blocked within limit");

   lim_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_split_s |=> s_r.limit == $past(wdata_i[31:16]))
      else $error("limit not written");
   lim_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !(wr_i && addr_i == PXBS_OFF_SPLIT) |=> $stable(s_r.limit))
      else $error("limit changed without write");
   lim_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_split_s |=> rdata_o[31:16] == $past(s_r.limit))
      else $error("limit read wrong");
   lim_seq_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_split_s ##1 rd_split_s |=> rdata_o[31:16] == $past(wdata_i[31:16], 2))
      else $error("written limit not read back");
   cap_seq_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_split_s ##1 rd_split_s |=> rdata_o[15:0] == PXBS_SPLIT_CAP)
      else $error("capability changed by write");

   ovr_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == PXBS_OFF_STATUS && !wdata_i[PXBS_OVR_BIT] && s_r.flags[PXBS_EV_OVR]
      |=> s_r.flags[PXBS_EV_OVR])
      else $error("overrun flag lost on zero write");
   dly_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == PXBS_OFF_STATUS && !wdata_i[PXBS_DLY_BIT] && s_r.flags[PXBS_EV_DLY]
      |=> s_r.flags[PXBS_EV_DLY])
      else $error("delayed flag lost on zero write");
   ovr_win_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == PXBS_OFF_STATUS && wdata_i[PXBS_OVR_BIT] && ev_overrun_i |=> s_r.flags[PXBS_EV_OVR])
      else $error("overrun event lost to clear");
   ovr_seq_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_ovr_clr_s ##1 rd_status_s |=> !rdata_o[PXBS_OVR_BIT])
      else $error("cleared overrun still read");

   irq_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_IRQ_STAT |=> rdata_o[3:0] == $past(s_r.irq_stat))
      else $error("event status read wrong");
   irq_rdclr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == PXBS_OFF_IRQ_STAT && !ev_overrun_i |=> !s_r.irq_stat[PXBS_EV_OVR])
      else $error("event status not cleared by read");
   // read data only after a read
   rdata_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !rd_i |=> rdata_o == 32'h00000000)
      else $error("read data without read");
endmodule

// ===== verif/pxbs_agent.sv
module pxbs_agent
   import pxbs_pkg::*;
(
   // clock
   input wire logic clk_i,
   // config address phase and split completions
   output pxbs_cfg_t cfg_o,
   output logic cpl_o,
   output logic [15:0] reqid_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cfg_o = '0;
      cpl_o = 1'b0;
      reqid_o = 16'h5A5A;
   end
   task automatic cfg_wr(input logic [3:0] cmd, input logic sel, input logic [15:0] ad);
      cfg_o <= '{1'b1, cmd, sel, ad};
      @(posedge clk_i);
      cfg_o <= '{1'b0, 4'h0, 1'b0, ~ad};
      @(posedge clk_i);
   endtask
   task automatic cpl(input logic [15:0] id);
      reqid_o <= id;
      cpl_o <= 1'b1;
      @(posedge clk_i);
      cpl_o <= 1'b0;
      reqid_o <= ~id;
      @(posedge clk_i);
   endtask
endmodule

// ===== verif/test_pxbs_regs.sv
module test_pxbs_regs
   import pxbs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rstn_i = 0, wr = 0, rd = 0, rev = 0, prst_n = 0, r64_n = 1, ok, irq, cpl;
   logic [7:0] addr = 8'h00, bus = 8'hFF;
   logic [31:0] wdata = 32'h0, q, rdata, seed = 32'h350C;
   logic [2:0] ev = 3'h0;
   logic [15:0] sz = 16'h0, os = 16'h0, lim, ad, cid, rid;
   logic [4:0] dev = 5'h1F;
   pxbs_cfg_t cfg;
   int num_errors = 0, checked = 0, cycles = 0;
   always #12.5 clk_i = ~clk_i;
   pxbs_agent i_pxbs_agent(.clk_i(clk_i), .cfg_o(cfg), .cpl_o(cpl), .reqid_o(rid));
   pxbs_regs i_pxbs_regs(.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .cfg_valid_i(cfg.valid), .cfg_cmd_i(cfg.cmd), .cfg_idsel_i(cfg.idsel), .cfg_ad_i(cfg.ad),
      .reverse_i(rev), .pci_rstn_i(prst_n), .req64_n_i(r64_n), .ev_discard_i(ev[0]), .ev_unexp_i(cpl),
      .unexp_reqid_i(rid), .ev_overrun_i(ev[1]), .req_size_i(sz), .outstanding_i(os), .split_req_i(ev[2]),
      .split_fwd_ok_o(ok), .completer_id_o(cid), .irq_o(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rreg(input logic [7:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      q = rdata;
      @(posedge clk_i);
   endtask
   task automatic pulse(input logic [2:0] v);
      ev <= v;
      @(posedge clk_i);
      ev <= 3'h0;
      @(posedge clk_i);
   endtask
   function automatic logic [31:0] st(input logic [3:0] fl, input logic c133, input logic c64);
      return {10'h0, fl, c133, c64, bus, dev, 3'h0};
   endfunction
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      prst_n <= 1'b1;
      @(posedge clk_i);
      rreg(PXBS_OFF_STATUS);
      chk(q, st(4'h0, 1'b0, 1'b0));
      rreg(PXBS_OFF_SPLIT);
      chk(q, 32'h00100010);
      rreg(8'h90);
      chk(q, 32'h0);
      chk({16'h0, cid}, 32'h0000FFF8);
      wreg(PXBS_OFF_IRQ_MASK, 32'hF);
      for (int i = 0; i < 8; i++) begin
         ad = 16'($random(seed)) & 16'hF8FF;
         i_pxbs_agent.cfg_wr(PXBS_CFG_WRITE, 1'b1, ad);
         dev = ad[15:11];
         // wrong command or idsel low must not load
         i_pxbs_agent.cfg_wr(i[0] ? 4'hA : PXBS_CFG_WRITE, i[0], ~ad);
         rreg(PXBS_OFF_STATUS);
         chk(q, st(4'h0, 1'b0, 1'b0));
      end
      bus = 8'($random(seed));
      wreg(PXBS_OFF_BUSNUM, {24'h0, bus});
      chk({16'h0, cid}, {16'h0, bus, dev, 3'h0});
      lim = (16'($random(seed)) | 16'h4000) & 16'h7FFF;
      wreg(PXBS_OFF_SPLIT, {lim, 16'h1234});
      rreg(PXBS_OFF_SPLIT);
      chk(q, {lim, 16'h0010});
      for (int i = 0; i < 8; i++) begin
         ad = 16'($random(seed)) & 16'h3FFF;
         sz <= ad;
         os <= i[0] ? lim - ad : 16'($random(seed)) & 16'h3FFF;
         @(negedge clk_i);
         chk({31'h0, ok}, {31'h0, os + sz <= lim});
         @(posedge clk_i);
      end
      sz <= 16'h3FFF;
      os <= lim;
      pulse(3'b100);
      wreg(PXBS_OFF_SPLIT, 32'hFFFF0000);
      os <= 16'h8000;
      sz <= 16'h8000;
      @(negedge clk_i);
      chk({31'h0, ok}, 32'h1);
      @(posedge clk_i);
      pulse(3'b011);
      i_pxbs_agent.cpl({bus, dev, 3'h0});
      rreg(PXBS_OFF_STATUS);
      chk(q, st(4'b1101, 1'b0, 1'b0));
      chk({31'h0, irq}, 32'h1);
      rreg(PXBS_OFF_IRQ_STAT);
      chk(q, 32'hD);
      rreg(PXBS_OFF_IRQ_STAT);
      chk(q, 32'h0);
      wreg(PXBS_OFF_STATUS, 32'hFFC00000);
      rreg(PXBS_OFF_STATUS);
      chk(q, st(4'b1101, 1'b0, 1'b0));
      wreg(PXBS_OFF_STATUS, 32'h00140000);
      rreg(PXBS_OFF_STATUS);
      chk(q, st(4'b1000, 1'b0, 1'b0));
      wreg(PXBS_OFF_STATUS, 32'hFFFFFFFF);
      wreg(PXBS_OFF_IRQ_MASK, 32'h0);
      pulse(3'b010);
      chk({31'h0, irq}, 32'h0);
      rev <= 1'b1;
      r64_n <= 1'b0;
      prst_n <= 1'b0;
      repeat (5) @(posedge clk_i);
      prst_n <= 1'b1;
      repeat (3) @(posedge clk_i);
      pulse(3'b001);
      i_pxbs_agent.cpl(~{bus, dev, 3'h0});
      i_pxbs_agent.cpl({bus, dev, 3'h0});
      rreg(PXBS_OFF_STATUS);
      chk(q, st(4'b0110, 1'b1, 1'b1));
      end_of_test();
   end
endmodule
